//--- rtl/gate_timer_consts.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 8-bit registers on a plain strobe port
// Notes: definitions only
`ifndef GATE_TIMER_CONSTS_SVH
`define GATE_TIMER_CONSTS_SVH

// register offsets
`define CTR_CTRL_OFS 8'h10
`define CMP_CTRL_OFS 8'h1c
`define CNT_LO_OFS 8'h20
`define CNT_HI_OFS 8'h21

// reset values and writable masks
`define CTR_CTRL_RST 8'h00
`define CMP_CTRL_RST 8'h02
`define CMP_CTRL_MASK 8'h1b

// counter_control fields
`define CC_ON 0
`define CC_CLK_SEL 1
`define CC_SYNC_N 2
`define CC_OSC_EN 3
`define CC_PS_LSB 4
`define CC_PS_MSB 5
`define CC_GATE_EN 6
`define CC_GATE_INV 7

// comparator_control_one fields
`define CM_SYNC 0
`define CM_GSS 1
`define CM_HYS 3
`define CM_ACS 4

// instruction clock is the oscillator divided by four
`define INSTR_DIV 4
`define INSTR_RISE_PH 2'h3
`define INSTR_FALL_PH 2'h1

`endif

//--- rtl/gate_timer_pkg.sv
// Purpose: shared types of the gated counter
// Assumes: nothing
// Notes: numbers live in gate_timer_consts.svh
package gate_timer_pkg;

  // where the counter clock comes from
  typedef enum logic [1:0] {
    SRC_INSTR,
    SRC_OSC,
    SRC_EXT
  } clk_src_t;

  // where the gate comes from
  typedef enum logic {
    GATE_FROM_CMP,
    GATE_FROM_PIN
  } gate_src_t;

endpackage

//--- rtl/prescale_divider.sv
// Purpose: divide a clock-source edge stream by 1, 2, 4 or 8
// Assumes: src_rise/src_fall are one-cycle enables of the source
// Notes: outputs are one-cycle enables for the prescaled clock edges
module prescale_divider #(
  parameter int PS_W = 2,
  parameter int CNT_W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // source edges
  input wire logic src_rise,
  input wire logic src_fall,
  input wire logic clr,
  input wire logic [PS_W-1:0] ps_sel,
  // prescaled edges
  output logic out_rise,
  output logic out_fall
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] last;
  logic [CNT_W-1:0] half;

  always_comb begin
    last = (CNT_W'(1) << ps_sel) - CNT_W'(1);
    half = last >> 1;
    nxt_cnt = cnt_ff;
    if (clr) begin
      nxt_cnt = '0;
    end else if (src_rise) begin
      nxt_cnt = (cnt_ff >= last) ? '0 : cnt_ff + CNT_W'(1);
    end
    // undivided: the source's own falling edge; else mid-period
    if (ps_sel == '0) begin
      out_rise = src_rise;
      out_fall = src_fall;
    end else begin
      out_rise = src_rise && (cnt_ff >= last) && !clr;
      out_fall = src_rise && (cnt_ff == half) && !clr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule // prescale_divider

//--- rtl/comparator_timer_gate.sv
// Purpose: gated 16-bit counter with comparator or pin gate source
// Assumes: clk is the oscillator clock; all inputs synchronous to clk
// Notes: clock edges of the counter source are one-cycle enables
`include "gate_timer_consts.svh"

module comparator_timer_gate
  import gate_timer_pkg::*;
#(
  parameter int AW = 8,
  parameter int CW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // analog comparator and pins
  input wire logic cmp_out,
  input wire logic gate_pin,
  input wire logic ext_clk_pin,
  // status
  output logic [CW-1:0] count_value,
  output logic count_wrap,
  output logic gate_open,
  output logic cmp_hysteresis_enable
);

  //////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0] ctr_ctrl_ff;
  logic [7:0] nxt_ctr_ctrl;
  logic [7:0] cmp_ctrl_ff;
  logic [7:0] nxt_cmp_ctrl;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic wrap_ff;
  logic nxt_wrap;
  logic gate_open_ff;
  logic nxt_gate_open;

  logic wr_ctr;
  logic wr_cmp;
  logic wr_lo;
  logic wr_hi;

  always_comb begin
    wr_ctr = 1'b0;
    wr_cmp = 1'b0;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    if (addr == AW'(`CTR_CTRL_OFS)) begin
      wr_ctr = wr_en;
    end else if (addr == AW'(`CMP_CTRL_OFS)) begin
      wr_cmp = wr_en;
    end else if (addr == AW'(`CNT_LO_OFS)) begin
      wr_lo = wr_en;
    end else if (addr == AW'(`CNT_HI_OFS)) begin
      wr_hi = wr_en;
    end
  end

  always_comb begin
    nxt_ctr_ctrl = ctr_ctrl_ff;
    nxt_cmp_ctrl = cmp_ctrl_ff;
    if (wr_ctr) begin
      nxt_ctr_ctrl = wdata;
    end
    if (wr_cmp) begin
      nxt_cmp_ctrl = wdata & `CMP_CTRL_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctr_ctrl_ff <= `CTR_CTRL_RST;
      cmp_ctrl_ff <= `CMP_CTRL_RST;
    end else begin
      ctr_ctrl_ff <= nxt_ctr_ctrl;
      cmp_ctrl_ff <= nxt_cmp_ctrl;
    end
  end

  // field views
  logic counter_on;
  logic gate_enable;
  logic gate_invert;
  logic [1:0] ps_sel;
  logic ext_clk_sel;
  logic cmp_output_sync;
  logic gate_source_select;
  logic alt_clock_select;

  always_comb begin
    counter_on = ctr_ctrl_ff[`CC_ON];
    gate_enable = ctr_ctrl_ff[`CC_GATE_EN];
    gate_invert = ctr_ctrl_ff[`CC_GATE_INV];
    ps_sel = ctr_ctrl_ff[`CC_PS_MSB:`CC_PS_LSB];
    ext_clk_sel = ctr_ctrl_ff[`CC_CLK_SEL];
    cmp_output_sync = cmp_ctrl_ff[`CM_SYNC];
    gate_source_select = cmp_ctrl_ff[`CM_GSS];
    alt_clock_select = cmp_ctrl_ff[`CM_ACS];
  end

  //////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, unmapped reads zero

  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_en) begin
      if (addr == AW'(`CTR_CTRL_OFS)) begin
        nxt_rdata = ctr_ctrl_ff;
      end else if (addr == AW'(`CMP_CTRL_OFS)) begin
        nxt_rdata = cmp_ctrl_ff & `CMP_CTRL_MASK;
      end else if (addr == AW'(`CNT_LO_OFS)) begin
        nxt_rdata = cnt_ff[7:0];
      end else if (addr == AW'(`CNT_HI_OFS)) begin
        nxt_rdata = cnt_ff[CW-1:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // counter clock source

  logic [1:0] instr_ph_ff;
  logic [1:0] nxt_instr_ph;
  logic ext_prev_ff;
  logic nxt_ext_prev;
  clk_src_t src;
  logic src_rise;
  logic src_fall;

  always_comb begin
    nxt_instr_ph = instr_ph_ff + 2'h1;
    nxt_ext_prev = ext_clk_pin;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      instr_ph_ff <= 2'h0;
      ext_prev_ff <= 1'b0;
    end else begin
      instr_ph_ff <= nxt_instr_ph;
      ext_prev_ff <= nxt_ext_prev;
    end
  end

  always_comb begin
    if (ext_clk_sel) begin
      src = SRC_EXT;
    end else if (alt_clock_select) begin
      src = SRC_OSC;
    end else begin
      src = SRC_INSTR;
    end
    case (src)
      SRC_OSC: begin
        // one oscillator period per clk: both edges every cycle
        src_rise = 1'b1;
        src_fall = 1'b1;
      end
      SRC_EXT: begin
        src_rise = ext_clk_pin && !ext_prev_ff;
        src_fall = !ext_clk_pin && ext_prev_ff;
      end
      default: begin
        src_rise = (instr_ph_ff == `INSTR_RISE_PH);
        src_fall = (instr_ph_ff == `INSTR_FALL_PH);
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // prescaler

  logic ps_rise;
  logic ps_fall;

  prescale_divider #(
    .PS_W(2),
    .CNT_W(3)
  ) u_prescale (
    .clk(clk),
    .rst(rst),
    .src_rise(src_rise),
    .src_fall(src_fall),
    .clr(wr_lo || wr_hi),
    .ps_sel(ps_sel),
    .out_rise(ps_rise),
    .out_fall(ps_fall)
  );

  //////////////////////////////////////////////////////////////////////
  // comparator synchronising latch

  logic cmp_latch_ff;
  logic nxt_cmp_latch;

  always_comb begin
    nxt_cmp_latch = cmp_latch_ff;
    if (ps_fall) begin
      nxt_cmp_latch = cmp_out;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_latch_ff <= 1'b0;
    end else begin
      cmp_latch_ff <= nxt_cmp_latch;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // gate selection

  gate_src_t gsrc;
  logic cmp_gate;
  logic gate_level;
  logic gate_ok;

  always_comb begin
    gsrc = gate_source_select ? GATE_FROM_PIN : GATE_FROM_CMP;
    // latched value when synchronised, live value otherwise
    cmp_gate = cmp_output_sync ? cmp_latch_ff : cmp_out;
    case (gsrc)
      GATE_FROM_PIN: gate_level = gate_pin;
      default: gate_level = cmp_gate;
    endcase
    // invert set: gate active high; clear: active low
    gate_ok = !gate_enable || (gate_level == gate_invert);
    nxt_gate_open = counter_on && gate_ok;
  end

  //////////////////////////////////////////////////////////////////////
  // gated counter

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_wrap = 1'b0;
    // increment only on the prescaled rising edge
    if (ps_rise && nxt_gate_open) begin
      nxt_cnt = cnt_ff + CW'(1);
      nxt_wrap = (cnt_ff == {CW{1'b1}});
    end
    // a software write wins over a simultaneous increment
    if (wr_lo) begin
      nxt_cnt = {cnt_ff[CW-1:8], wdata};
      nxt_wrap = 1'b0;
    end
    if (wr_hi) begin
      nxt_cnt = {wdata, cnt_ff[7:0]};
      nxt_wrap = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
      wrap_ff <= 1'b0;
      gate_open_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      wrap_ff <= nxt_wrap;
      gate_open_ff <= nxt_gate_open;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    rdata = rdata_ff;
    count_value = cnt_ff;
    count_wrap = wrap_ff;
    gate_open = gate_open_ff;
    cmp_hysteresis_enable = cmp_ctrl_ff[`CM_HYS];
  end

endmodule // comparator_timer_gate

//--- bench/gate_timer_properties.sv
// Purpose: port-level properties of the gated counter
// Assumes: one clock, synchronous active-high reset
// Notes: bound to comparator_timer_gate from the bench top
module gate_timer_properties #(
  parameter int AW = 8,
  parameter int CW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  // status
  input wire logic [CW-1:0] count_value,
  input wire logic count_wrap,
  input wire logic gate_open,
  input wire logic cmp_hysteresis_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  a_read_idle: assert property (
    !$past(rd_en) |-> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unimpl_zero: assert property (
    $past(rd_en) && $past(addr) == 8'h1c |-> (rdata & 8'he4) == 8'h00)
    else $error("unimplemented bits read nonzero");
  a_unmapped_zero: assert property (
    $past(rd_en) && $past(addr) == 8'h05 |-> rdata == 8'h00)
    else $error("unmapped address read nonzero");
  a_readback_mask: assert property (
    wr_en && addr == 8'h1c ##1 rd_en && addr == 8'h1c
    |=> rdata == ($past(wdata, 2) & 8'h1b))
    else $error("comparator control readback wrong");
  a_hys_follow: assert property (
    wr_en && addr == 8'h1c
    |=> cmp_hysteresis_enable == (($past(wdata) & 8'h08) != 8'h00))
    else $error("hysteresis output does not follow bit 3");
  a_count_step: assert property (
    !$past(rst) && !$past(wr_en) && count_value != $past(count_value)
    |-> count_value == $past(count_value) + 1'b1)
    else $error("counter moved by other than one");
  a_gate_needed: assert property (
    !$past(rst) && !$past(wr_en) && count_value != $past(count_value)
    |-> gate_open || $past(gate_open))
    else $error("counter advanced with gate closed");
  a_stop_off: assert property (
    wr_en && addr == 8'h10 && !wdata[0] ##1 !wr_en
    |=> $stable(count_value))
    else $error("counter advanced while off");
  a_wrap_pulse: assert property (
    count_wrap |-> count_value == '0 && $past(count_value) == {CW{1'b1}})
    else $error("wrap pulse without rollover");
endmodule // gate_timer_properties

//--- bench/gate_source_model.sv
// Purpose: comparator output and gate pin seen by the block
// Assumes: levels requested by the bench
// Notes: slow mode delays the comparator by three cycles
module gate_source_model (
  // clock
  input wire logic clk,
  // requested levels
  input wire logic want_cmp,
  input wire logic want_pin,
  input wire logic slow,
  // to the block
  output logic cmp_out,
  output logic gate_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] dly_ff = 3'h0;
  initial cmp_out = 1'b0;
  // comparator settles one or three cycles after a change
  always @(posedge clk) begin
    dly_ff <= {dly_ff[1:0], want_cmp};
    cmp_out <= slow ? dly_ff[1] : want_cmp;
  end
  assign gate_pin = want_pin;
endmodule // gate_source_model

//--- bench/test_comparator_timer_gate.sv
// Purpose: self-checking bench for comparator_timer_gate
// Assumes: 50 MHz clock, reset held 8 cycles
// Notes: counts are read back through the register port, rollovers counted on count_wrap
`include "gate_timer_consts.svh"
module test_comparator_timer_gate;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic want_cmp = 1'b0;
  logic want_pin = 1'b0;
  logic slow = 1'b0;
  logic cmp_out;
  logic gate_pin;
  logic [7:0] rdata;
  logic [15:0] count_value;
  logic count_wrap;
  logic [7:0] n_wrap = 8'h00;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [15:0] n;
  int n_fail = 0;
  int comparisons = 0;
  int seed = 21;
  int r;

  always #10 clk = ~clk;

  comparator_timer_gate i_comparator_timer_gate (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .cmp_out(cmp_out), .gate_pin(gate_pin),
    .ext_clk_pin(1'b0), .count_value(count_value), .count_wrap(count_wrap),
    .gate_open(), .cmp_hysteresis_enable());
  gate_source_model i_gate_source_model (
    .clk(clk), .want_cmp(want_cmp), .want_pin(want_pin), .slow(slow),
    .cmp_out(cmp_out), .gate_pin(gate_pin));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic rd, input logic [7:0] a,
                     input logic [7:0] d);
    wr_en <= w;
    rd_en <= rd;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask
  // count from zero for 800 cycles, then read both bytes
  task automatic run(input logic [7:0] ctl, input logic [7:0] cm,
                     input logic [15:0] e);
    bus(1'b1, 1'b0, `CMP_CTRL_OFS, cm);
    bus(1'b1, 1'b0, `CNT_LO_OFS, 8'h00);
    bus(1'b1, 1'b0, `CNT_HI_OFS, 8'h00);
    bus(1'b1, 1'b0, `CTR_CTRL_OFS, ctl | 8'h01);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (798) @(posedge clk);
    bus(1'b1, 1'b0, `CTR_CTRL_OFS, ctl);
    rd_exp(`CNT_LO_OFS, e[7:0]);
    rd_exp(`CNT_HI_OFS, e[15:8]);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rd_d) begin
      check(rdata, exp_q.pop_front());
    end
    rd_d <= rd_en;
  end

  // counts rollover pulses
  always @(posedge clk) begin
    if (count_wrap === 1'b1) begin
      n_wrap <= n_wrap + 8'h01;
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    finish_test;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_exp(`CTR_CTRL_OFS, `CTR_CTRL_RST);
    rd_exp(`CMP_CTRL_OFS, `CMP_CTRL_RST);
    rd_exp(8'h05, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      bus(1'b1, 1'b0, `CMP_CTRL_OFS, r[7:0]);
      rd_exp(`CMP_CTRL_OFS, r[7:0] & `CMP_CTRL_MASK);
    end
    // instruction and oscillator clock sources at every prescale, gate off
    for (int i = 0; i < 8; i++) begin
      n = (16'd800 >> i[1:0]) >> (i[2] ? 0 : 2);
      run({2'b00, i[1:0], 4'h0}, {3'h0, i[2], 4'h0}, n);
    end
    want_cmp <= 1'b1;
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (8) @(posedge clk);
    run(8'hc0, 8'h11, 16'd800);
    for (int i = 0; i < 10; i++) begin
      r = $random(seed);
      want_cmp <= r[0];
      want_pin <= r[1];
      slow <= r[5];
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      repeat (8) @(posedge clk);
      n = (r[r[2]] == r[3]) ? 16'd800 : 16'd0;
      run({r[3], 7'h40}, {4'h1, 2'b00, r[2], r[4]}, n);
    end
    // two steps from 0xfffe: exactly one rollover pulse
    bus(1'b1, 1'b0, `CMP_CTRL_OFS, 8'h10);
    bus(1'b1, 1'b0, `CNT_HI_OFS, 8'hff);
    bus(1'b1, 1'b0, `CNT_LO_OFS, 8'hfe);
    bus(1'b1, 1'b0, `CTR_CTRL_OFS, 8'h01);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    bus(1'b1, 1'b0, `CTR_CTRL_OFS, 8'h00);
    rd_exp(`CNT_LO_OFS, 8'h00);
    rd_exp(`CNT_HI_OFS, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (2) @(posedge clk);
    check(n_wrap, 8'h01);
    finish_test;
  end
endmodule // test_comparator_timer_gate

bind comparator_timer_gate gate_timer_properties #(.AW(AW), .CW(CW))
  i_gate_timer_properties (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .count_value(count_value), .count_wrap(count_wrap), .gate_open(gate_open),
  .cmp_hysteresis_enable(cmp_hysteresis_enable));
